// ---- dv/dar_chk.sv ----
// bank checker
`timescale 1ns/100ps
module dar_chk (
  input logic clock,
  input logic rst,
  input logic [6:0] address_strap_pin,
  input logic reg_wr,
  input logic reg_rd,
  input logic [7:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic [7:0] reg_rdata,
  input logic [6:0] own_target_address,
  input logic logic_reset_out,
  input logic full_logic_reset_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire lo = logic_reset_out;
  wire fo = full_logic_reset_out;
  wire w1 = reg_wr && reg_addr == 8'h01 && !lo;
  wire a0 = reg_rd && reg_addr == 8'h00;
  wire st = own_target_address == address_strap_pin;
  a_full_go: assert property (w1 && reg_wdata[1] |=> fo && lo)
    else $error("no full");
  a_keep_go: assert property (w1 && reg_wdata[1:0] == 2'b01
    |=> lo && !fo) else $error("bad keep");
  a_pulse_len: assert property ($rose(lo) |-> lo[*5] ##1 !lo)
    else $error("pulse len");
  a_src_strap: assert property (a0 ##1 !reg_rdata[0] |-> st)
    else $error("not strap");
  a_src_prog: assert property (a0 ##1 reg_rdata[0] |->
    own_target_address == reg_rdata[7:1]) else $error("not prog");
  a_rst_bits: assert property (reg_rd && reg_addr == 8'h01 |=>
    reg_rdata[1:0] == 2'b00) else $error("bits set");
  a_full_reload: assert property ($rose(fo) |=> st)
    else $error("no reload");
  a_keep_regs: assert property (lo && !fo && !reg_wr |=>
    $stable(own_target_address)) else $error("regs lost");
  cover property (w1 && reg_wdata[1]);
  cover property (w1 && !reg_wdata[1]);
  cover property (a0 ##1 reg_rdata[0]);
endmodule : dar_chk
bind dar_top dar_chk dar_chk_i (.*);

// ---- dv/dar_host.sv ----
// host model issuing single-byte register cycles
`timescale 1ns/100ps
module dar_host (
  input logic clock,
  output logic wr,
  output logic rd,
  output logic [7:0] ad,
  output logic [7:0] wd
);
  initial {wr, rd, ad, wd} = '0;
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(posedge clock) #1;
    {wr, rd, ad, wd} = {w, !w, a, d};
    @(posedge clock) #1;
    {wr, rd, wd} = {2'b00, ~d};
  endtask : acc
endmodule : dar_host

// ---- dv/dar_top_tb.sv ----
// bench for the address and reset bank
`timescale 1ns/100ps
module dar_top_tb;
  import dar_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic wr, rd;
  logic [7:0] ad, wd, q;
  logic [6:0] strap = 7'h5a;
  logic [6:0] own;
  logic lo, fo;
  int failures, cmp_count;
  dar_top dar_top_i (.clock, .rst, .address_strap_pin(strap), .reg_wr(wr),
    .reg_rd(rd), .reg_addr(ad), .reg_wdata(wd), .reg_rdata(q),
    .own_target_address(own), .logic_reset_out(lo),
    .full_logic_reset_out(fo));
  dar_host dar_host_i (.clock, .wr, .rd, .ad, .wd);
  task automatic test_done;
    if (failures == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  task automatic cmp8(input logic [7:0] got, e);
    cmp_count++;
    if (got !== e) begin
      failures++;
      $display("MISMATCH %0t got %h want %h", $time, got, e);
    end
  endtask : cmp8
  task automatic rd8(input logic [7:0] a, e);
    dar_host_i.acc(1'b0, a, 8'h00);
    cmp8(q, e);
  endtask : rd8
  // a soft reset pulse: its kind on entry, then its length, bounded
  task automatic pulse(input logic full);
    int n;
    n = 0;
    cmp8({7'h00, fo}, {7'h00, full});
    while (lo && n < 20) begin
      @(posedge clock) #1;
      n++;
    end
    cmp8(8'(n), 8'(DAR_PULSE_CYCLES + 1));
  endtask : pulse
  initial forever #2 clock = ~clock;
  initial begin
    repeat (8) @(posedge clock);
    #1 rst = 1'b0;
    rd8(8'h00, 8'hb4);
    cmp8({1'b0, own}, 8'h5a);
    rd8(8'h01, 8'h04);
    dar_host_i.acc(1'b1, 8'h00, 8'h67);
    cmp8({1'b0, own}, 8'h33);
    dar_host_i.acc(1'b1, 8'h01, 8'h05);
    pulse(1'b0);
    rd8(8'h00, 8'h67);
    rd8(8'h01, 8'h04);
    dar_host_i.acc(1'b1, 8'h01, 8'hf4);
    rd8(8'h01, 8'hf4);
    dar_host_i.acc(1'b1, 8'h01, 8'hf6);
    pulse(1'b1);
    rd8(8'h00, 8'hb4);
    cmp8({1'b0, own}, 8'h5a);
    rd8(8'h01, 8'h04);
    dar_host_i.acc(1'b1, 8'h01, 8'h03);
    pulse(1'b1);
    rst = 1'b1;
    strap = 7'h21;
    repeat (8) @(posedge clock);
    #1 rst = 1'b0;
    rd8(8'h00, 8'h42);
    cmp8({1'b0, own}, 8'h21);
    rd8(8'h09, 8'h00);
    test_done;
  end
endmodule : dar_top_tb

// ---- hw/dar_pkg.sv ----
// package: offsets, field positions, reset values and timing for address/reset bank
package dar_pkg;
  localparam logic [7:0] DAR_OFS_TARGET_ADDR = 8'h00;
  localparam logic [7:0] DAR_OFS_SOFT_RESET = 8'h01;
  localparam int DAR_ADDR_MSB = 7;
  localparam int DAR_ADDR_LSB = 1;
  localparam int DAR_SRC_SEL_BIT = 0;
  localparam int DAR_FULL_RST_BIT = 1;
  localparam int DAR_KEEP_RST_BIT = 0;
  localparam logic [7:0] DAR_SOFT_RESET_RST = 8'h04;
  localparam logic [7:0] DAR_SOFT_RESET_KEEP_MASK = 8'hfc;
  localparam logic DAR_SRC_SEL_RST = 1'b0;
  // reset pulse length minus one, in core clock cycles
  localparam int DAR_PULSE_CYCLES = 4;
  localparam int DAR_CNT_W = 3;
  typedef enum logic [1:0] {
    DAR_ST_IDLE = 2'b00,
    DAR_ST_FULL = 2'b01,
    DAR_ST_KEEP = 2'b10
  } dar_state_t;
endpackage : dar_pkg

// ---- hw/dar_pulse_timer.sv ----
// pulse timer: holds a reset pulse for a fixed number of cycles
`timescale 1ns/100ps
module dar_pulse_timer #(
  parameter int CYCLES = 4,
  parameter int CNT_W = 3
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  output logic busy
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (start) begin
      cnt_d = CNT_W'(CYCLES);
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - CNT_W'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign busy = (cnt_q != '0);
endmodule : dar_pulse_timer

// ---- hw/dar_top.sv ----
// target address register and software reset register bank
`timescale 1ns/100ps
module dar_top
  import dar_pkg::*;
#(
  parameter int PULSE_CYCLES = DAR_PULSE_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [6:0] address_strap_pin,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic [6:0] own_target_address,
  output logic logic_reset_out,
  output logic full_logic_reset_out
);
  logic [6:0] strap_q;
  logic [6:0] strap_d;
  logic strap_taken_q;
  logic strap_taken_d;
  logic [6:0] addr_q;
  logic [6:0] addr_d;
  logic src_q;
  logic src_d;
  logic [7:0] rsv_q;
  logic [7:0] rsv_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [6:0] own_q;
  logic [6:0] own_d;
  logic rst_any_q;
  logic rst_any_d;
  logic rst_full_q;
  logic rst_full_d;
  dar_state_t st_q;
  dar_state_t st_d;
  logic timer_start;
  logic timer_busy;
  logic wr_addr;
  logic wr_rst;
  logic full_req;
  logic keep_req;
  logic reg_clear;

  assign wr_addr = reg_wr && (reg_addr == DAR_OFS_TARGET_ADDR);
  assign wr_rst = reg_wr && (reg_addr == DAR_OFS_SOFT_RESET);
  assign full_req = wr_rst && reg_wdata[DAR_FULL_RST_BIT];
  assign keep_req = wr_rst && reg_wdata[DAR_KEEP_RST_BIT] && !full_req;
  // registers are cleared by the pin reset and by the full soft reset
  assign reg_clear = (st_q == DAR_ST_FULL);

  // strap captured once after reset release, kept across soft resets
  always_ff @(posedge clock) begin
    if (rst) begin
      strap_taken_q <= 1'b0;
      strap_q <= '0;
    end else begin
      strap_taken_q <= strap_taken_d;
      strap_q <= strap_d;
    end
  end

  always_comb begin
    strap_taken_d = 1'b1;
    strap_d = strap_q;
    if (!strap_taken_q) begin
      strap_d = address_strap_pin;
    end
  end

  always_comb begin
    addr_d = addr_q;
    src_d = src_q;
    rsv_d = rsv_q;
    if (!strap_taken_q) begin
      addr_d = address_strap_pin;
    end else if (reg_clear) begin
      addr_d = strap_q;
      src_d = DAR_SRC_SEL_RST;
      rsv_d = DAR_SOFT_RESET_RST;
    end else if (wr_addr) begin
      addr_d = reg_wdata[DAR_ADDR_MSB:DAR_ADDR_LSB];
      src_d = reg_wdata[DAR_SRC_SEL_BIT];
    end else if (wr_rst) begin
      // only reserved bits store; the reset bits are self-clearing
      rsv_d = reg_wdata & DAR_SOFT_RESET_KEEP_MASK;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      addr_q <= '0;
      src_q <= DAR_SRC_SEL_RST;
      rsv_q <= DAR_SOFT_RESET_RST;
    end else begin
      addr_q <= addr_d;
      src_q <= src_d;
      rsv_q <= rsv_d;
    end
  end

  // effective address registered from next values: strap unless overridden
  always_comb begin
    own_d = strap_d;
    if (src_d) begin
      own_d = addr_d;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      own_q <= '0;
    end else begin
      own_q <= own_d;
    end
  end

  // reset sequencer: a full reset outranks a keep-registers reset
  always_comb begin
    st_d = st_q;
    timer_start = 1'b0;
    unique case (st_q)
      DAR_ST_IDLE: begin
        if (full_req) begin
          st_d = DAR_ST_FULL;
          timer_start = 1'b1;
        end else if (keep_req) begin
          st_d = DAR_ST_KEEP;
          timer_start = 1'b1;
        end
      end
      DAR_ST_FULL, DAR_ST_KEEP: begin
        if (!timer_busy) begin
          st_d = DAR_ST_IDLE;
        end
      end
      default: st_d = DAR_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= DAR_ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // reset outputs are flops, so no decode glitch reaches a reset net
  always_comb begin
    rst_any_d = 1'b0;
    rst_full_d = 1'b0;
    unique case (st_d)
      DAR_ST_IDLE: begin
        rst_any_d = 1'b0;
      end
      DAR_ST_FULL: begin
        rst_any_d = 1'b1;
        rst_full_d = 1'b1;
      end
      DAR_ST_KEEP: begin
        rst_any_d = 1'b1;
      end
      default: begin
        rst_any_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rst_any_q <= 1'b0;
      rst_full_q <= 1'b0;
    end else begin
      rst_any_q <= rst_any_d;
      rst_full_q <= rst_full_d;
    end
  end

  dar_pulse_timer #(
    .CYCLES(PULSE_CYCLES),
    .CNT_W(DAR_CNT_W)
  ) u_timer (
    .clock(clock),
    .rst(rst),
    .start(timer_start),
    .busy(timer_busy)
  );

  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      unique case (reg_addr)
        DAR_OFS_TARGET_ADDR: rdata_d = {addr_q, src_q};
        DAR_OFS_SOFT_RESET: rdata_d = rsv_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign own_target_address = own_q;
  assign logic_reset_out = rst_any_q;
  assign full_logic_reset_out = rst_full_q;
endmodule : dar_top
